// ### two_wire_defines.svh
// constants for the two-wire master/slave port
`ifndef TWO_WIRE_DEFINES_SVH
`define TWO_WIRE_DEFINES_SVH

`define TW_SYS_CLK_MHZ   20
`define TW_SYS_PERIOD_NS (1000 / `TW_SYS_CLK_MHZ)
`define TW_GLITCH_NS     50
`define TW_FILT_CYC      ((`TW_GLITCH_NS + `TW_SYS_PERIOD_NS - 1) / `TW_SYS_PERIOD_NS)
`define TW_BYTE_BITS     4'h8
`define TW_DAT_RST       8'h00
`define TW_IRQ_VECTOR    16'h003B
`define TW_LINE_SCL      0
`define TW_LINE_SDA      1

`endif

// ### two_wire_pkg.sv
// types shared by the two-wire master/slave port
package two_wire_pkg;

  typedef logic [6:0] slave_addr_t;
  typedef logic [7:0] byte_t;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ACK_ADDR = 4'h2,
    ST_RX       = 4'h3,
    ST_RX_ACK   = 4'h4,
    ST_TX       = 4'h5,
    ST_TX_ACK   = 4'h6,
    ST_HOLD     = 4'h7,
    ST_HALT     = 4'h8
  } slave_state_e;

endpackage

// ### line_filter.sv
// two-flop synchroniser and spike filter for the clock and data lines
`timescale 1ns/10ps
`include "two_wire_defines.svh"

module line_filter (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // raw lines, index 0 clock, index 1 data
  input  wire logic [1:0] line_raw,
  // filtered lines
  output logic      [1:0] line_flt
);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_line
      logic       s1_ff;
      logic       s2_ff;
      logic [1:0] cnt_ff;
      logic       out_ff;

      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          s1_ff <= 1'b1;
          s2_ff <= 1'b1;
        end else begin
          s1_ff <= line_raw[g];
          s2_ff <= s1_ff;
        end
      end

      // a change must hold past the spike limit before it is believed
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          cnt_ff <= 2'h0;
          out_ff <= 1'b1;
        end else if (s2_ff == out_ff) begin
          cnt_ff <= 2'h0;
        end else if (cnt_ff == 2'(`TW_FILT_CYC)) begin
          cnt_ff <= 2'h0;
          out_ff <= s2_ff;
        end else begin
          cnt_ff <= cnt_ff + 2'h1;
        end
      end

      assign line_flt[g] = out_ff;
    end
  endgenerate

endmodule

// ### two_wire_port.sv
// two-wire port: bit-driven software master and hardware addressed slave
//
// Function
// - repeated start honoured only after receiving
// - reject spikes under 50 ns on lines (the data input bit is latched from the raw, unfiltered pins)
// - master select bit picks master, else slave
// - master drives data per enable and bit
// - master drives clock from clock bit whenever active
// - data latched into input bit on clock rise
// - reset leaves the interface in slave mode
// - active if peripheral enable clear or relocated
// - match address registers, data via one register
// - start, address, direction received sets flag
// - interrupt needs both enables and the flag
// - data register access clears the flag
// - second access per flag halts until reset or slave mode left
// - interrupt vectors to 003BH per byte
// - first byte shows address and direction
// - direction flag holds master read/write bit
// - clock stretched low until flag cleared
// - flag only for bytes followed by ack
// - keep flagging bytes until stop or reset
// - stop or nack returns slave to idle
// - interface reset forces idle from anywhere
// - four programmable seven-bit slave addresses
`timescale 1ns/10ps
`include "two_wire_defines.svh"

module two_wire_port (
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  // mode and enable controls
  input  wire logic                      master_select_bit,
  input  wire logic                      serial_periph_enable_bit,
  input  wire logic                      serial_periph_relocate_bit,
  input  wire logic                      interface_reset_bit,
  // software master bits
  input  wire logic                      data_out_enable_bit,
  input  wire logic                      data_out_bit,
  input  wire logic                      clock_out_bit,
  output logic                           data_in_bit,
  // slave addresses
  input  wire two_wire_pkg::slave_addr_t slave_addr0,
  input  wire two_wire_pkg::slave_addr_t slave_addr1,
  input  wire two_wire_pkg::slave_addr_t slave_addr2,
  input  wire two_wire_pkg::slave_addr_t slave_addr3,
  // data register access
  input  wire logic                      dat_wr,
  input  wire two_wire_pkg::byte_t       dat_wdata,
  input  wire logic                      dat_rd,
  output two_wire_pkg::byte_t            dat_rdata,
  output logic                           byte_complete_flag,
  output logic                           direction_flag,
  output logic                           halted,
  // core interrupt request
  input  wire logic                      irq_enable_bit,
  input  wire logic                      global_irq_enable_bit,
  output logic                           core_irq,
  output logic [15:0]                    irq_vector,
  // bus pins
  input  wire logic                      serial_clock_pin,
  input  wire logic                      serial_data_pin,
  output logic                           serial_clock_drive,
  output logic                           serial_clock_oe,
  output logic                           serial_data_drive,
  output logic                           serial_data_oe
);
  import two_wire_pkg::*;

  slave_state_e st_ff;
  byte_t        shreg_ff;
  byte_t        dat_ff;
  logic [3:0]   bitcnt_ff;
  logic [1:0]   line_flt;
  logic         dir_ff, was_rx_ff, ack_ok_ff, flag_ff, seen_ff;
  logic         scl_d_ff, sda_d_ff, link_din_ff, din_s1_ff, din_s2_ff;
  logic         scl_drv_ff, scl_oe_ff, sda_drv_ff, sda_oe_ff;
  logic         nxt_scl_drv, nxt_scl_oe, nxt_sda_drv, nxt_sda_oe;
  logic         scl_f, sda_f, scl_rise, scl_fall, start_ev, stop_ev;
  logic         active, slave_on, iface_rst, access, second_access;
  logic         addr_hit, start_ok, fsm_run, flag_set, capture;

  // spike filters on both lines
  line_filter u_filter (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .line_raw ({serial_data_pin, serial_clock_pin}),
    .line_flt (line_flt)
  );
  assign scl_f = line_flt[`TW_LINE_SCL];
  assign sda_f = line_flt[`TW_LINE_SDA];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_f;
      sda_d_ff <= sda_f;
    end
  end
  assign scl_rise = scl_f & ~scl_d_ff;
  assign scl_fall = ~scl_f & scl_d_ff;
  assign start_ev = scl_f & scl_d_ff & sda_d_ff & ~sda_f;
  assign stop_ev  = scl_f & scl_d_ff & ~sda_d_ff & sda_f;
  assign active    = ~serial_periph_enable_bit | serial_periph_relocate_bit;
  assign slave_on  = active & ~master_select_bit;
  assign iface_rst = interface_reset_bit;

  // data input bit: captured in the bus clock's own domain, then brought over
  always_ff @(posedge serial_clock_pin or posedge rst) begin
    if (rst) begin
      link_din_ff <= 1'b0;
    end else begin
      link_din_ff <= serial_data_pin;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      din_s1_ff <= 1'b0;
      din_s2_ff <= 1'b0;
    end else begin
      din_s1_ff <= link_din_ff;
      din_s2_ff <= din_s1_ff;
    end
  end
  assign data_in_bit = din_s2_ff;

  assign addr_hit = (shreg_ff[7:1] == slave_addr0) || (shreg_ff[7:1] == slave_addr1) ||
                    (shreg_ff[7:1] == slave_addr2) || (shreg_ff[7:1] == slave_addr3);
  assign access        = dat_rd | dat_wr;
  // a second touch of the data register before the next byte is a firmware fault
  assign second_access = slave_on & access & seen_ff & ~flag_set;
  assign start_ok      = start_ev & ((st_ff == ST_IDLE) | was_rx_ff);
  // no second-access term: it would loop back through flag_set
  assign fsm_run       = slave_on & ~iface_rst & (st_ff != ST_HALT) & ~stop_ev & ~start_ok;

  assign flag_set = fsm_run & scl_fall &
                    ((st_ff == ST_ACK_ADDR) | (st_ff == ST_RX_ACK) |
                     ((st_ff == ST_TX_ACK) & ack_ok_ff));
  assign capture  = fsm_run & scl_fall & ((st_ff == ST_ACK_ADDR) | (st_ff == ST_RX_ACK));

  // slave sequencer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff     <= ST_IDLE;
      shreg_ff  <= `TW_DAT_RST;
      bitcnt_ff <= 4'h0;
      dir_ff    <= 1'b0;
      was_rx_ff <= 1'b0;
      ack_ok_ff <= 1'b0;
    end else if (iface_rst || !slave_on) begin
      st_ff     <= ST_IDLE;
      bitcnt_ff <= 4'h0;
      was_rx_ff <= 1'b0;
    end else if (second_access) begin
      st_ff <= ST_HALT;
    end else if (st_ff == ST_HALT) begin
      st_ff <= ST_HALT;
    end else if (stop_ev) begin
      st_ff     <= ST_IDLE;
      was_rx_ff <= 1'b0;
    end else if (start_ok) begin
      st_ff     <= ST_ADDR;
      bitcnt_ff <= 4'h0;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          bitcnt_ff <= 4'h0;
        end
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            shreg_ff  <= {shreg_ff[6:0], sda_f};
            bitcnt_ff <= bitcnt_ff + 4'h1;
          end else if (scl_fall && bitcnt_ff == `TW_BYTE_BITS) begin
            bitcnt_ff <= 4'h0;
            if (st_ff == ST_RX) begin
              st_ff <= ST_RX_ACK;
            end else if (addr_hit) begin
              st_ff     <= ST_ACK_ADDR;
              dir_ff    <= shreg_ff[0];
              was_rx_ff <= ~shreg_ff[0];
            end else begin
              st_ff <= ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR, ST_RX_ACK: begin
          if (scl_fall) begin
            st_ff <= ST_HOLD;
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bitcnt_ff <= bitcnt_ff + 4'h1;
          end else if (scl_fall) begin
            if (bitcnt_ff == `TW_BYTE_BITS) begin
              st_ff     <= ST_TX_ACK;
              bitcnt_ff <= 4'h0;
            end else begin
              shreg_ff <= {shreg_ff[6:0], 1'b0};
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            ack_ok_ff <= ~sda_f;
          end else if (scl_fall) begin
            st_ff <= ack_ok_ff ? ST_HOLD : ST_IDLE;
          end
        end
        ST_HOLD: begin
          // leave the stretch only once firmware has serviced the byte
          if (!flag_ff) begin
            bitcnt_ff <= 4'h0;
            if (dir_ff) begin
              st_ff    <= ST_TX;
              shreg_ff <= dat_ff;
            end else begin
              st_ff <= ST_RX;
            end
          end
        end
        default: begin
          st_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // data register: firmware writes, received bytes land here too
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dat_ff <= `TW_DAT_RST;
    end else if (dat_wr) begin
      dat_ff <= dat_wdata;
    end else if (capture) begin
      dat_ff <= shreg_ff;
    end
  end

  // byte flag: a new byte wins over a clear in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flag_ff <= 1'b0;
    end else if (iface_rst) begin
      flag_ff <= 1'b0;
    end else if (flag_set) begin
      flag_ff <= 1'b1;
    end else if (access) begin
      flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      seen_ff <= 1'b0;
    end else if (iface_rst || flag_set) begin
      seen_ff <= 1'b0;
    end else if (access) begin
      seen_ff <= 1'b1;
    end
  end

  // pin drivers; the slave only ever pulls low, open-drain style
  always_comb begin
    nxt_scl_drv = 1'b1;
    nxt_scl_oe  = 1'b0;
    nxt_sda_drv = 1'b1;
    nxt_sda_oe  = 1'b0;
    if (!active) begin
      nxt_scl_oe = 1'b0;
    end else if (master_select_bit) begin
      nxt_scl_oe  = 1'b1;
      nxt_scl_drv = clock_out_bit;
      nxt_sda_oe  = data_out_enable_bit;
      nxt_sda_drv = data_out_bit;
    end else begin
      // stretch until the hold is left, so a first transmit bit is set up before release
      if (st_ff == ST_HOLD) begin
        nxt_scl_oe  = 1'b1;
        nxt_scl_drv = 1'b0;
      end
      if (st_ff == ST_ACK_ADDR || st_ff == ST_RX_ACK ||
          (st_ff == ST_TX && !shreg_ff[7]) ||
          (st_ff == ST_HOLD && dir_ff && !flag_ff && !dat_ff[7])) begin
        nxt_sda_oe  = 1'b1;
        nxt_sda_drv = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_drv_ff <= 1'b1;
      scl_oe_ff  <= 1'b0;
      sda_drv_ff <= 1'b1;
      sda_oe_ff  <= 1'b0;
    end else begin
      scl_drv_ff <= nxt_scl_drv;
      scl_oe_ff  <= nxt_scl_oe;
      sda_drv_ff <= nxt_sda_drv;
      sda_oe_ff  <= nxt_sda_oe;
    end
  end

  assign serial_clock_drive = scl_drv_ff;
  assign serial_clock_oe    = scl_oe_ff;
  assign serial_data_drive  = sda_drv_ff;
  assign serial_data_oe     = sda_oe_ff;

  assign dat_rdata          = dat_ff;
  assign byte_complete_flag = flag_ff;
  assign direction_flag     = dir_ff;
  assign halted             = (st_ff == ST_HALT);
  // the vector is fixed; the core fetches from it on each flagged byte while both interrupt enables are set
  assign core_irq           = flag_ff & irq_enable_bit & global_irq_enable_bit;
  assign irq_vector         = `TW_IRQ_VECTOR;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_master_clock: assert property (active && master_select_bit |=>
    serial_clock_oe && serial_clock_drive == $past(clock_out_bit))
    else $error("master clock pin not following clock bit");
  a_master_data: assert property (active && master_select_bit && !data_out_enable_bit |=>
    !serial_data_oe)
    else $error("master data driver on while enable clear");
  a_inactive_pins: assert property (!active |=> !serial_clock_oe && !serial_data_oe)
    else $error("pins driven while interface disabled");
  a_flag_clear: assert property (flag_ff && access && !flag_set && !iface_rst |=>
    !byte_complete_flag)
    else $error("flag survived data register access");
  a_irq_gate: assert property (core_irq |-> byte_complete_flag && irq_enable_bit &&
    global_irq_enable_bit)
    else $error("interrupt without flag and both enables");
  a_clock_stretch: assert property (st_ff == ST_HOLD && flag_ff && slave_on |=>
    serial_clock_oe && !serial_clock_drive)
    else $error("clock not held low while byte pending");
  a_second_halt: assert property (second_access |=> halted ##1 (halted || $past(iface_rst)))
    else $error("second access did not halt");
  a_reset_idle: assert property (iface_rst |=> st_ff == ST_IDLE && !byte_complete_flag)
    else $error("interface reset did not return to idle");
  a_nack_idle: assert property (fsm_run && !second_access && st_ff == ST_TX_ACK &&
    scl_fall && !ack_ok_ff |=> st_ff == ST_IDLE && !byte_complete_flag)
    else $error("nack did not end the transfer");
  a_stop_idle: assert property (slave_on && stop_ev && !iface_rst && !second_access &&
    st_ff != ST_HALT |=> st_ff == ST_IDLE)
    else $error("stop did not return to idle");
  a_addr_shown: assert property (capture && !dat_wr && st_ff == ST_ACK_ADDR |=>
    byte_complete_flag && dat_rdata == $past(shreg_ff) && direction_flag == $past(shreg_ff[0]))
    else $error("address byte not presented with flag");

  c_addressed: cover property (flag_set && st_ff == ST_ACK_ADDR);
  c_tx_acked: cover property (flag_set && st_ff == ST_TX_ACK);
  c_rx_byte: cover property (flag_set && st_ff == ST_RX_ACK);
  c_halt: cover property (second_access);

endmodule

// ### two_wire_bus_master_model.sv
// bus master model for the far side of the two-wire port, timed by the link clock
`timescale 1ns/10ps

module two_wire_bus_master_model (
  // link clock
  input  wire logic link_clk,
  // resolved bus levels
  input  wire logic scl_in,
  input  wire logic sda_in,
  // open-drain pulls, high pulls the line low
  output logic      scl_low,
  output logic      sda_low,
  // a clock stretch outlasted the wait limit
  output logic      stuck
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    stuck   = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
  endtask

  // honour a stretch, but bounded so a stuck slave cannot hang the run
  task automatic scl_high;
    int w;
    tick(8);
    scl_low <= 1'b0;
    w = 0;
    tick(1);
    while (scl_in !== 1'b1 && w < 4000) begin
      tick(1);
      w++;
    end
    if (w >= 4000) stuck <= 1'b1;
    tick(4);
  endtask

  // data only moves while the clock is low, two ticks clear of the fall
  task automatic bit_cycle(output logic smp);
    scl_high();
    smp = sda_in;
    tick(4);
    scl_low <= 1'b1;
    tick(2);
  endtask

  // also serves as a repeated start when the clock is low
  task automatic start_cond;
    sda_low <= 1'b0;
    scl_high();
    sda_low <= 1'b1;
    tick(4);
    scl_low <= 1'b1;
    tick(2);
  endtask

  task automatic stop_cond;
    sda_low <= 1'b1;
    scl_high();
    sda_low <= 1'b0;
    tick(8);
  endtask

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic d;
    for (int i = 7; i >= 0; i--) begin
      sda_low <= ~b[i];
      bit_cycle(d);
    end
    sda_low <= 1'b0;
    bit_cycle(d);
    ack = ~d;
  endtask

  task automatic rd_byte(input logic ack, output logic [7:0] b);
    logic d;
    sda_low <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d);
      b[i] = d;
    end
    sda_low <= ack;
    bit_cycle(d);
    sda_low <= 1'b0;
  endtask
endmodule

// ### two_wire_master_slave_port_bench.sv
// self-checking bench for the two-wire port against a bus master model
`timescale 1ns/10ps

module two_wire_master_slave_port_bench;
  import two_wire_pkg::*;

  typedef struct packed {
    logic  dir;
    logic  chk;
    byte_t dat;
  } note_s;

  logic        sys_clk, link_clk, rst, master_select_bit, interface_reset_bit;
  logic        serial_periph_enable_bit, serial_periph_relocate_bit;
  logic        data_out_enable_bit, data_out_bit, clock_out_bit, data_in_bit;
  slave_addr_t slave_addr0, slave_addr1, slave_addr2, slave_addr3;
  logic        dat_wr, dat_rd, byte_complete_flag, direction_flag, halted;
  byte_t       dat_wdata, dat_rdata, b, got;
  logic        irq_enable_bit, global_irq_enable_bit, core_irq;
  logic [15:0] irq_vector;
  logic        serial_clock_drive, serial_clock_oe, serial_data_drive, serial_data_oe;
  logic        scl_low, sda_low, master_stuck, tb_sda_low, tb_scl_low, fw_auto, ack;
  logic [6:0]  base;
  int          miscompares, checks_done, cycles, seed;
  note_s       note, notes[$];
  byte_t       txq[$];

  // open-drain resolution with pull-ups
  wire scl = (serial_clock_oe ? serial_clock_drive : 1'b1) & ~scl_low & ~tb_scl_low;
  wire sda = (serial_data_oe ? serial_data_drive : 1'b1) & ~sda_low & ~tb_sda_low;

  two_wire_port DUT (
    .sys_clk, .rst, .master_select_bit, .serial_periph_enable_bit,
    .serial_periph_relocate_bit, .interface_reset_bit, .data_out_enable_bit,
    .data_out_bit, .clock_out_bit, .data_in_bit, .slave_addr0, .slave_addr1,
    .slave_addr2, .slave_addr3, .dat_wr, .dat_wdata, .dat_rd, .dat_rdata,
    .byte_complete_flag, .direction_flag, .halted, .irq_enable_bit,
    .global_irq_enable_bit, .core_irq, .irq_vector, .serial_clock_pin(scl),
    .serial_data_pin(sda), .serial_clock_drive, .serial_clock_oe,
    .serial_data_drive, .serial_data_oe
  );

  two_wire_bus_master_model far_end (
    .link_clk, .scl_in(scl), .sda_in(sda), .scl_low, .sda_low, .stuck(master_stuck)
  );

  always #25 sys_clk = ~sys_clk;

  initial begin
    link_clk = 1'b0;
    #37;
    forever #80 link_clk = ~link_clk;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // run is about 10k cycles; the ceiling leaves room for slow stretches
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic slave_write(input logic [6:0] a, input byte_t d);
    @(posedge sys_clk);
    irq_enable_bit <= 1'($urandom);
    global_irq_enable_bit <= 1'($urandom);
    // short spike on a clock high phase must not add a bit
    fork
      begin
        @(posedge scl);
        #300 tb_scl_low = 1'b1;
        #40 tb_scl_low = 1'b0;
      end
    join_none
    notes.push_back({1'b0, 1'b1, a, 1'b0});
    far_end.start_cond();
    far_end.wr_byte({a, 1'b0}, ack);
    check("addr_ack", 16'h1, ack);
    notes.push_back({1'b0, 1'b1, d});
    far_end.wr_byte(d, ack);
    check("data_ack", 16'h1, ack);
  endtask

  // watches each flag against the oldest note, then plays firmware while fw_auto is set
  initial forever begin
    @(posedge byte_complete_flag);
    @(negedge sys_clk);
    if (notes.size() == 0) begin
      check("flag_unexpected", 16'h0, 16'h1);
    end else begin
      note = notes.pop_front();
      check("direction", note.dir, direction_flag);
      if (note.chk)
        check("rx_byte", note.dat, dat_rdata);
      check("irq", irq_enable_bit & global_irq_enable_bit, core_irq);
    end
    repeat (3) @(negedge sys_clk);
    check("scl_hold", 16'h1, serial_clock_oe & ~serial_clock_drive);
    if (fw_auto) begin
      @(posedge sys_clk);
      if (direction_flag) begin
        dat_wr <= 1'b1;
        dat_wdata <= txq.pop_front();
      end else begin
        dat_rd <= 1'b1;
      end
      @(posedge sys_clk);
      dat_wr <= 1'b0;
      dat_rd <= 1'b0;
      @(negedge sys_clk);
      check("flag_clear", 16'h0, byte_complete_flag);
    end
  end

  initial begin
    seed = $urandom(46320);
    base = 7'($urandom);
    {sys_clk, rst, master_select_bit, interface_reset_bit} = 4'h4;
    {serial_periph_enable_bit, serial_periph_relocate_bit, dat_wr, dat_rd} = 4'h0;
    {data_out_enable_bit, data_out_bit, clock_out_bit, irq_enable_bit} = 4'h0;
    {global_irq_enable_bit, tb_sda_low, tb_scl_low, fw_auto} = 4'h1;
    dat_wdata = 8'h00;
    slave_addr0 = {base[6:2], 2'h0};
    slave_addr1 = {base[6:2], 2'h1};
    slave_addr2 = {base[6:2], 2'h2};
    slave_addr3 = {base[6:2], 2'h3};
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    check("scl_oe_rst", 16'h0, serial_clock_oe);
    check("sda_oe_rst", 16'h0, serial_data_oe);
    check("flag_rst", 16'h0, byte_complete_flag);
    check("dat_rst", 16'h00, dat_rdata);
    check("vector", 16'h003B, irq_vector);
    master_select_bit <= 1'b1;
    repeat (8) begin
      @(posedge sys_clk);
      {data_out_enable_bit, data_out_bit, clock_out_bit} <= 3'($urandom);
      tb_sda_low <= 1'($urandom);
      repeat (3) @(negedge sys_clk);
      check("sda_oe", data_out_enable_bit, serial_data_oe);
      if (data_out_enable_bit)
        check("sda_drive", data_out_bit, serial_data_drive);
      check("scl_out", {1'b1, clock_out_bit}, {serial_clock_oe, serial_clock_drive});
      @(posedge sys_clk);
      {data_out_enable_bit, clock_out_bit} <= 2'h0;
      repeat (3) @(posedge sys_clk);
      clock_out_bit <= 1'b1;
      repeat (6) @(negedge sys_clk);
      check("data_in", !tb_sda_low, data_in_bit);
    end
    @(posedge sys_clk);
    {serial_periph_enable_bit, tb_sda_low} <= 2'h2;
    repeat (3) @(negedge sys_clk);
    check("inactive", 16'h0, serial_clock_oe);
    @(posedge sys_clk);
    serial_periph_relocate_bit <= 1'b1;
    repeat (3) @(negedge sys_clk);
    check("relocated", 16'h1, serial_clock_oe);
    @(posedge sys_clk);
    {master_select_bit, serial_periph_enable_bit, serial_periph_relocate_bit} <= 3'h0;
    repeat (3) @(negedge sys_clk);
    check("slave_mode", 16'h0, serial_clock_oe);
    for (int i = 0; i < 4; i++) begin
      slave_write({base[6:2], 2'(i)}, byte_t'($urandom));
      far_end.stop_cond();
      repeat (4) @(negedge sys_clk);
      check("stop_idle", 16'h0, serial_clock_oe | serial_data_oe);
    end
    b = byte_t'($urandom);
    txq.push_back(b);
    txq.push_back(~b);
    slave_write(slave_addr1, b ^ 8'h5A);
    notes.push_back({1'b1, 1'b1, slave_addr1, 1'b1});
    far_end.start_cond();
    far_end.wr_byte({slave_addr1, 1'b1}, ack);
    check("rd_addr_ack", 16'h1, ack);
    notes.push_back({1'b1, 1'b0, 8'h00});
    far_end.rd_byte(1'b1, got);
    check("tx_byte", b, got);
    far_end.rd_byte(1'b0, got);
    check("tx_last", byte_t'(~b), got);
    repeat (20) @(negedge sys_clk);
    check("nack_idle", 16'h0, serial_data_oe | byte_complete_flag);
    far_end.stop_cond();
    far_end.start_cond();
    far_end.wr_byte({~base[6:2], 2'h0, 1'b0}, ack);
    check("bad_addr_ack", 16'h0, ack);
    far_end.stop_cond();
    fw_auto = 1'b0;
    notes.push_back({1'b0, 1'b1, slave_addr0, 1'b0});
    far_end.start_cond();
    far_end.wr_byte({slave_addr0, 1'b0}, ack);
    repeat (100) @(negedge sys_clk);
    check("stretch", 16'h1, serial_clock_oe & ~serial_clock_drive);
    repeat (2) begin
      @(posedge sys_clk);
      dat_rd <= 1'b1;
      @(posedge sys_clk);
      dat_rd <= 1'b0;
    end
    repeat (2) @(negedge sys_clk);
    check("halted", 16'h1, halted);
    check("halt_release", 16'h0, serial_clock_oe);
    @(posedge sys_clk);
    interface_reset_bit <= 1'b1;
    @(posedge sys_clk);
    interface_reset_bit <= 1'b0;
    repeat (2) @(negedge sys_clk);
    check("reset_idle", 16'h0, {halted, byte_complete_flag});
    fw_auto = 1'b1;
    far_end.stop_cond();
    slave_write(slave_addr3, byte_t'($urandom));
    far_end.stop_cond();
    repeat (20) @(negedge sys_clk);
    check("notes_left", 16'h0, 16'(notes.size()));
    check("master_stuck", 16'h0, master_stuck);
    finish_test();
  end
endmodule
